// ==== rtl/sfmrc_params.svh ====
`ifndef SFMRC_PARAMS_SVH
`define SFMRC_PARAMS_SVH

// instruction codes
`define SFMRC_OP_ENTER_4B   8'hB7
`define SFMRC_OP_EXIT_4B    8'hE9
`define SFMRC_OP_RST_ARM    8'h66
`define SFMRC_OP_RST_GO     8'h99

// timing figures and clock rate
`define SFMRC_CLK_HZ        25000000
`define SFMRC_SW_RST_NS     300000
`define SFMRC_HW_RST_NS     1000
`define SFMRC_SW_RST_CYC    ((`SFMRC_SW_RST_NS * (`SFMRC_CLK_HZ / 1000000)) / 1000)
`define SFMRC_HW_RST_CYC    ((`SFMRC_HW_RST_NS * (`SFMRC_CLK_HZ / 1000000) + 999) / 1000)

// address layout
`define SFMRC_ADDR_W        32
`define SFMRC_EXT_LSB       24
`define SFMRC_BITS_1LINE    3'h7
`define SFMRC_BITS_4LINE    3'h1

`endif

// ==== rtl/sfmrc_pkg.sv ====
package sfmrc_pkg;

	typedef enum logic {
		SFMRC_ADDR3 = 1'b0,
		SFMRC_ADDR4 = 1'b1
	} sfmrc_amode_t;

	// configuration bits seen by the block
	typedef struct packed {
		logic quad_lines_enable;
		logic pin_is_reset;
		logic power_up_addr_mode_bit;
	} sfmrc_cfg_t;

	// status seen by the core
	typedef struct packed {
		logic current_addr_mode_flag;
		logic four_line_instruction_mode;
		logic selected;
		logic paused;
		logic resetting;
		logic standby;
	} sfmrc_stat_t;

endpackage

// ==== rtl/sfmrc_ctrl.sv ====
`timescale 1ns/1ps
`include "sfmrc_params.svh"
module sfmrc_ctrl
	import sfmrc_pkg::*;
#(
	parameter int SW_RST_CYC = `SFMRC_SW_RST_CYC,
	parameter int HW_RST_CYC = `SFMRC_HW_RST_CYC
) (
	// system clock, reset and power-on indication
	input  wire logic                     clk,
	input  wire logic                     srst,
	input  wire logic                     por_active,
	// serial link, clocked by its own clock
	input  wire logic                     sclk,
	input  wire logic                     cs_n,
	input  wire logic [3:0]               data_in,
	output      logic                     so_out,
	output      logic                     so_oe,
	input  wire logic                     so_data,
	input  wire logic                     so_want,
	// shared pause/reset pin and dedicated reset pin
	input  wire logic                     data_line_3,
	input  wire logic                     reset_pin_n,
	// configuration and core side
	input  wire sfmrc_cfg_t               cfg,
	input  wire logic                     four_line_set,
	input  wire logic                     write_busy,
	input  wire logic [7:0]               ext_addr,
	input  wire logic [31:0]              addr_bytes,
	output      logic [`SFMRC_ADDR_W-1:0] full_addr,
	output      logic [7:0]               opcode,
	output      logic                     opcode_valid,
	output      logic                     abort_write,
	output      sfmrc_stat_t              status,
	output      logic                     status_bit_16
);

	// ---- system domain: synchronisers (clk) ----
	logic [1:0] pin3_s_r, rpin_s_r, cs_s_r;
	always_ff @(posedge clk) begin
		pin3_s_r <= {pin3_s_r[0], data_line_3};
		rpin_s_r <= {rpin_s_r[0], reset_pin_n};
		cs_s_r   <= {cs_s_r[0], cs_n};
	end

	// shared pin as reset only when pin-select set
	// quad enable strips the reset role
	logic shared_rst_low;
	assign shared_rst_low = cfg.pin_is_reset && !cfg.quad_lines_enable
		&& !pin3_s_r[1];

	logic hw_low;
	assign hw_low = !rpin_s_r[1] || shared_rst_low;

	// width counted on free clock; relies on host width
	logic [15:0] hw_cnt_r;
	logic        hw_fire;
	always_ff @(posedge clk) begin
		if (srst || !hw_low)
			hw_cnt_r <= 16'h0000;
		else if (hw_cnt_r < 16'(HW_RST_CYC))
			hw_cnt_r <= hw_cnt_r + 16'h0001;
	end
	// held as a level, so abort stands for the whole reset
	// and not just for one cycle the core might miss
	assign hw_fire = hw_low && hw_cnt_r == 16'(HW_RST_CYC);

	// decoded events, one clk pulse each, made at frame end below
	logic go_ev_r, b7_ev_r, e9_ev_r;
	logic sw_go_ev, b7_ev, e9_ev;
	assign sw_go_ev = go_ev_r;
	assign b7_ev    = b7_ev_r;
	assign e9_ev    = e9_ev_r;

	logic [15:0] sw_cnt_r;
	logic        sw_busy;
	always_ff @(posedge clk) begin
		if (srst || por_active)
			sw_cnt_r <= 16'h0000;
		else if (sw_go_ev && sw_cnt_r == 16'h0000)
			sw_cnt_r <= 16'(SW_RST_CYC);
		else if (sw_cnt_r != 16'h0000)
			sw_cnt_r <= sw_cnt_r - 16'h0001;
	end
	assign sw_busy = sw_cnt_r != 16'h0000;

	// power-on, held pin, busy all block instructions
	logic block_all;
	assign block_all = por_active || hw_low || sw_busy;

	// hardware reset aborts any running write
	assign abort_write = hw_fire || por_active;

	// address mode, reloaded after any reset
	sfmrc_amode_t amode_r;
	always_ff @(posedge clk) begin
		if (srst || por_active || hw_low || sw_busy)
			amode_r <= sfmrc_amode_t'(cfg.power_up_addr_mode_bit);
		else if (b7_ev)
			amode_r <= SFMRC_ADDR4;
		else if (e9_ev)
			amode_r <= SFMRC_ADDR3;
	end
	assign status_bit_16 = amode_r;

	// four-line mode dropped on any reset
	logic qmode_r;
	always_ff @(posedge clk) begin
		if (srst || por_active || hw_low || sw_busy)
			qmode_r <= 1'b0;
		else if (four_line_set)
			qmode_r <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			full_addr <= '0;
		else if (amode_r == SFMRC_ADDR4)
			full_addr <= addr_bytes;
		else
			full_addr <= {ext_addr, addr_bytes[`SFMRC_EXT_LSB-1:0]};
	end

	// link and clk split:
	// sclk only runs inside a frame, so nothing that must happen
	// after the last sclk rise can live in the link domain. the
	// link side therefore only captures bits and a frame toggle.
	// the clk side waits for select to rise through its two
	// flops; by then sclk has stopped and the captured words are
	// still, so they are read there as quasi-static data.
	// limitation: the host must leave a gap of a few clk cycles
	// between deselect and the next first sclk rise.

	// armed only after select seen high, captured in clk domain
	logic cs_armed_r;
	always_ff @(posedge clk) begin
		if (srst || por_active)
			cs_armed_r <= 1'b0;
		else if (cs_s_r[1])
			cs_armed_r <= 1'b1;
	end

	// pause latch: pin level taken while sclk low
	// select high clears the pause
	// level sensitive on purpose: sclk may be stopped in a pause
	logic pause_r;
	logic pause_en;
	assign pause_en = !cfg.quad_lines_enable && !cfg.pin_is_reset;
	always_latch begin
		if (cs_n || !pause_en)
			pause_r <= 1'b0;
		else if (!sclk)
			pause_r <= !data_line_3;
	end

	// frame start: first sclk rise after select falls
	logic link_act_r;
	always_ff @(posedge sclk or posedge cs_n or posedge srst) begin
		if (cs_n || srst)
			link_act_r <= 1'b0;
		else if (!pause_r)
			link_act_r <= 1'b1;
	end

	// link capture, position frozen while paused
	// the count saturates so a long data phase never wraps
	logic [3:0] edge_cnt_r;
	logic [7:0] word1_r;
	logic [7:0] word4_r;
	logic       frame_tg_r;
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			edge_cnt_r <= 4'h0;
			frame_tg_r <= 1'b0;
		end else if (!pause_r) begin
			if (!link_act_r) begin
				edge_cnt_r <= 4'h1;
				frame_tg_r <= ~frame_tg_r;
			end else if (edge_cnt_r != 4'hF) begin
				edge_cnt_r <= edge_cnt_r + 4'h1;
			end
		end
	end

	// opcode msb first; each word stops at its own length
	// both widths are captured, the clk side picks one by mode
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			word1_r <= 8'h00;
			word4_r <= 8'h00;
		end else if (!pause_r) begin
			if (!link_act_r) begin
				word1_r <= {7'h00, data_in[0]};
				word4_r <= {4'h0, data_in};
			end else begin
				if (edge_cnt_r <= {1'b0, `SFMRC_BITS_1LINE})
					word1_r <= {word1_r[6:0], data_in[0]};
				if (edge_cnt_r <= {1'b0, `SFMRC_BITS_4LINE})
					word4_r <= {word4_r[3:0], data_in};
			end
		end
	end

	// frame end seen on clk once select has passed both flops
	// reset high so a select held high through reset is no edge
	logic cs_d_r;
	logic frame_seen_r;
	logic frame_end;
	always_ff @(posedge clk) begin
		if (srst)
			cs_d_r <= 1'b1;
		else
			cs_d_r <= cs_s_r[1];
	end
	assign frame_end = cs_s_r[1] && !cs_d_r;

	// a frame with no sclk rise leaves the toggle alone, so an
	// old word is never decoded a second time
	always_ff @(posedge clk) begin
		if (srst)
			frame_seen_r <= 1'b0;
		else if (frame_end)
			frame_seen_r <= frame_tg_r;
	end

	// pause state crossed, one stage later than select, so
	// at frame end it still shows the level before deselection
	logic [1:0] pause_s_r;
	logic       pause_d_r;
	always_ff @(posedge clk) begin
		pause_s_r <= {pause_s_r[0], pause_r};
		pause_d_r <= pause_s_r[1];
	end

	// one captured word against one instruction code
	function automatic logic op_is(input logic [7:0] word,
		input logic [7:0] code);
		return word == code;
	endfunction

	logic [7:0] word_sel;
	logic       word_full;
	logic       take;
	assign word_sel  = qmode_r ? word4_r : word1_r;
	assign word_full = qmode_r
		? (edge_cnt_r > {1'b0, `SFMRC_BITS_4LINE})
		: (edge_cnt_r > {1'b0, `SFMRC_BITS_1LINE});
	// only the first opcode of a frame, only a full one
	assign take = frame_end && cs_armed_r && !block_all && word_full
		&& !pause_d_r && (frame_tg_r != frame_seen_r);

	// arm survives only into the very next taken opcode
	logic armed_r;
	always_ff @(posedge clk) begin
		if (srst || block_all)
			armed_r <= 1'b0;
		else if (take)
			armed_r <= op_is(word_sel, `SFMRC_OP_RST_ARM);
	end

	// decoded instructions as single clk pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			go_ev_r <= 1'b0;
			b7_ev_r <= 1'b0;
			e9_ev_r <= 1'b0;
		end else begin
			go_ev_r <= take && armed_r
				&& op_is(word_sel, `SFMRC_OP_RST_GO);
			b7_ev_r <= take && op_is(word_sel, `SFMRC_OP_ENTER_4B);
			e9_ev_r <= take && op_is(word_sel, `SFMRC_OP_EXIT_4B);
		end
	end

	// opcode word and its one-cycle valid for the core
	// the word stands until the next taken frame
	always_ff @(posedge clk) begin
		if (srst) begin
			opcode       <= 8'h00;
			opcode_valid <= 1'b0;
		end else begin
			opcode_valid <= take;
			if (take)
				opcode <= word_sel;
		end
	end

	// output floats during pause or while deselected
	assign so_out = so_data;
	assign so_oe  = so_want && !cs_n && !pause_r && !block_all;

	// standby when deselected and no write cycle
	assign status.current_addr_mode_flag   = amode_r;
	assign status.four_line_instruction_mode = qmode_r;
	assign status.selected   = !cs_s_r[1] && cs_armed_r;
	assign status.paused     = pause_r;
	assign status.resetting  = block_all;
	assign status.standby    = cs_s_r[1] && !write_busy;

endmodule // sfmrc_ctrl

// ==== dv/sfmrc_ctrl_props.sv ====
`timescale 1ns/1ps
module sfmrc_ctrl_props
	import sfmrc_pkg::*;
#(
	parameter int HW_RST_CYC = 25
) (
	// clock, resets and inputs
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        por_active,
	input wire logic        cs_n,
	input wire logic        reset_pin_n,
	input wire logic        write_busy,
	input wire sfmrc_cfg_t  cfg,
	input wire logic [7:0]  ext_addr,
	input wire logic [31:0] addr_bytes,
	// outputs
	input wire logic [31:0] full_addr,
	input wire logic [7:0]  opcode,
	input wire logic        opcode_valid,
	input wire logic        so_oe,
	input wire sfmrc_stat_t status,
	input wire logic        status_bit_16
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] low_cnt_r;
	// saturates so a long hold stays counted
	always_ff @(posedge clk) begin
		if (srst || reset_pin_n)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hFF)
			low_cnt_r <= low_cnt_r + 8'h01;
	end
	sequence s_mode_op;
		opcode_valid && !status.resetting && opcode inside {8'hB7, 8'hE9};
	endsequence
	sequence s_calm;
		!$past(srst) && $stable(ext_addr) && $stable(addr_bytes)
			&& $stable(status_bit_16);
	endsequence
	property p_mode;
		s_mode_op |-> ##[0:4] status_bit_16 == (opcode == 8'hB7);
	endproperty
	property p_addr3;
		s_calm ##0 !status_bit_16 |-> full_addr == {ext_addr, addr_bytes[23:0]};
	endproperty
	property p_addr4;
		s_calm ##0 status_bit_16 |-> full_addr == addr_bytes;
	endproperty
	property p_por;
		por_active[*5] |-> !opcode_valid && !status.selected;
	endproperty
	property p_pause;
		status.paused |-> !cfg.quad_lines_enable && !cfg.pin_is_reset && !so_oe;
	endproperty
	property p_desel;
		cs_n[*5] |-> !status.selected && !status.paused;
	endproperty
	property p_standby;
		(cs_n && !write_busy)[*6] |-> status.standby;
	endproperty
	property p_hwr;
		low_cnt_r == HW_RST_CYC + 4 |-> status.resetting;
	endproperty
	property p_refuse;
		low_cnt_r >= 8 |-> !opcode_valid;
	endproperty
	property p_reload;
		$fell(status.resetting) |-> ##[0:2] (!status.four_line_instruction_mode
			&& status_bit_16 == cfg.power_up_addr_mode_bit);
	endproperty
	a_mode: assert property (p_mode) else $error("mode change");
	a_addr3: assert property (p_addr3) else $error("addr 3b");
	a_addr4: assert property (p_addr4) else $error("addr 4b");
	a_por: assert property (p_por) else $error("por leak");
	a_pause: assert property (p_pause) else $error("pause");
	a_desel: assert property (p_desel) else $error("deselect");
	a_standby: assert property (p_standby) else $error("standby");
	a_hwr: assert property (p_hwr) else $error("hw reset");
	a_refuse: assert property (p_refuse) else $error("refuse");
	a_reload: assert property (p_reload) else $error("reload");
endmodule // sfmrc_ctrl_props

bind sfmrc_ctrl sfmrc_ctrl_props #(.HW_RST_CYC(HW_RST_CYC)) u_sfmrc_ctrl_props (
	.clk(clk), .srst(srst), .por_active(por_active), .cs_n(cs_n),
	.reset_pin_n(reset_pin_n), .write_busy(write_busy), .cfg(cfg),
	.ext_addr(ext_addr), .addr_bytes(addr_bytes), .full_addr(full_addr),
	.opcode(opcode), .opcode_valid(opcode_valid), .so_oe(so_oe),
	.status(status), .status_bit_16(status_bit_16));

// ==== dv/sfmrc_host.sv ====
`timescale 1ns/1ps
module sfmrc_host (
	// link toward the device
	output logic       sclk,
	output logic       cs_n,
	output logic [3:0] data_in
);
	initial begin
		sclk = 0;
		cs_n = 0;
		data_in = 4'h5;
	end
	task sel(input logic v);
		cs_n = v;
	endtask
	task frame(input logic [7:0] op, input bit q);
		cs_n = 0;
		for (int i = 0; i < (q ? 2 : 8); i++) begin
			data_in = q ? op[7-4*i -: 4] : {3'h0, op[7-i]};
			#62.5 sclk = 1;
			#62.5 sclk = 0;
		end
		// released lines must not look like held data
		data_in = ~data_in;
		#62.5 cs_n = 1;
		#125;
	endtask
endmodule // sfmrc_host

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import sfmrc_pkg::*;
	logic        clk = 0, srst = 0, por_active = 1, so_want = 0;
	logic        so_data = 0, so_out, opcode_valid;
	logic [7:0]  opcode;
	int          n_valid = 0;
	logic        data_line_3 = 1, reset_pin_n = 1, four_line_set = 0;
	logic        write_busy = 0, exp_mode;
	logic        sclk, cs_n, so_oe, abort_write, status_bit_16;
	logic [3:0]  data_in;
	logic [7:0]  ext_addr = 8'h00;
	logic [31:0] addr_bytes = 32'h0, full_addr;
	sfmrc_cfg_t  cfg = '0;
	sfmrc_stat_t status;
	int          fails = 0, comparisons = 0, cyc = 0, seed = 5;
	always #20 clk = ~clk;
	sfmrc_host u_sfmrc_host (.sclk(sclk), .cs_n(cs_n), .data_in(data_in));
	sfmrc_ctrl #(.SW_RST_CYC(100), .HW_RST_CYC(25)) u_sfmrc_ctrl (
		.clk(clk), .srst(srst), .por_active(por_active), .sclk(sclk),
		.cs_n(cs_n), .data_in(data_in), .so_out(so_out), .so_oe(so_oe),
		.so_data(so_data), .so_want(so_want), .data_line_3(data_line_3),
		.reset_pin_n(reset_pin_n), .cfg(cfg), .four_line_set(four_line_set),
		.write_busy(write_busy), .ext_addr(ext_addr), .opcode(opcode),
		.addr_bytes(addr_bytes), .full_addr(full_addr),
		.opcode_valid(opcode_valid),
		.abort_write(abort_write), .status(status),
		.status_bit_16(status_bit_16));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task test_done;
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task op(input logic [7:0] o, input bit q);
		u_sfmrc_host.frame(o, q);
		cyc_n(8);
	endtask
	task mode_chk;
		ext_addr = 8'($random(seed));
		addr_bytes = $random(seed);
		so_data = 1'($random(seed));
		cyc_n(3);
		chk("so", so_data, so_out);
		chk("mode", exp_mode, status_bit_16);
		chk("addr", exp_mode ? addr_bytes : {ext_addr, addr_bytes[23:0]},
			full_addr);
	endtask
	always @(negedge clk) begin
		if (opcode_valid === 1'b1)
			n_valid++;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		#1 srst = 1;
		cfg.power_up_addr_mode_bit = 1'($random(seed));
		cyc_n(10);
		srst = 0;
		por_active = 0;
		cyc_n(4);
		chk("sel", 0, status.selected);
		u_sfmrc_host.sel(1);
		exp_mode = cfg.power_up_addr_mode_bit;
		mode_chk;
		for (int i = 0; i < 4; i++) begin
			op(i[0] ? 8'hE9 : 8'hB7, 0);
			exp_mode = !i[0];
			mode_chk;
			chk("opc", i[0] ? 8'hE9 : 8'hB7, opcode);
		end
		por_active = 1;
		op(8'hB7, 0);
		por_active = 0;
		exp_mode = cfg.power_up_addr_mode_bit;
		mode_chk;
		cfg.power_up_addr_mode_bit = 1;
		op(8'hB7, 0);
		op(8'h66, 0);
		op(8'hE9, 0);
		op(8'h99, 0);
		exp_mode = 0;
		mode_chk;
		four_line_set = 1;
		cyc_n(1);
		four_line_set = 0;
		op(8'h66, 1);
		op(8'h99, 1);
		op(8'hE9, 0);
		exp_mode = 1;
		mode_chk;
		cyc_n(100);
		chk("4line", 0, status.four_line_instruction_mode);
		cfg.power_up_addr_mode_bit = 0;
		write_busy = 1;
		// pin held low over a whole frame, past 1us
		for (int i = 0; i < 3; i++) begin
			op(8'hE9, 0);
			cfg.quad_lines_enable = i > 0;
			cfg.pin_is_reset = 1;
			data_line_3 = i == 2;
			reset_pin_n = i != 2;
			u_sfmrc_host.frame(8'hB7, 0);
			cyc_n(2);
			chk("abort", i != 1, abort_write);
			{data_line_3, reset_pin_n} = 2'b11;
			exp_mode = i == 1;
			mode_chk;
		end
		write_busy = 0;
		cfg.pin_is_reset = 0;
		so_want = 1;
		for (int i = 0; i < 2; i++) begin
			cfg.quad_lines_enable = i;
			u_sfmrc_host.sel(0);
			cyc_n(4);
			data_line_3 = 0;
			cyc_n(6);
			chk("paused", !i, status.paused);
			if (i == 0)
				chk("oe", 0, so_oe);
			u_sfmrc_host.sel(1);
			cyc_n(6);
			chk("paused", 0, status.paused);
			data_line_3 = 1;
		end
		chk("standby", 1, status.standby);
		write_busy = 1;
		cyc_n(4);
		chk("standby", 0, status.standby);
		chk("valid", 14, n_valid);
		test_done;
	end
endmodule // tb_top
